// ---- rtl/cic_pkg.sv ----
// Constants for the interrupt code, transmit priority and bit timing block.
// Assumes a single clock domain and an APB register port.
`default_nettype none
package cic_pkg;
  localparam logic [11:0] CIC_STATUS_OFFS = 12'h000;
  localparam logic [11:0] CIC_CTRL_OFFS = 12'h004;
  localparam logic [11:0] CIC_IRQ_OFFS = 12'h008;
  localparam logic [11:0] CIC_TXPRIO_OFFS = 12'h00c;
  localparam logic [11:0] CIC_TIMING_OFFS = 12'h010;
  localparam logic [11:0] CIC_BITSTAT_OFFS = 12'h014;
  localparam logic [4:0] CIC_CODE_NONE = 5'h00;
  localparam logic [4:0] CIC_CODE_ERR = 5'h02;
  localparam logic [4:0] CIC_CODE_TX2 = 5'h04;
  localparam logic [4:0] CIC_CODE_TX1 = 5'h06;
  localparam logic [4:0] CIC_CODE_TX0 = 5'h08;
  localparam logic [4:0] CIC_CODE_RX1_LEG = 5'h0a;
  localparam logic [4:0] CIC_CODE_RX0_LEG = 5'h0c;
  localparam logic [4:0] CIC_CODE_WAKE = 5'h0e;
  localparam logic [4:0] CIC_CODE_RX0_ENH = 5'h10;
  localparam logic [4:0] CIC_CODE_RX1_ENH = 5'h11;
  localparam logic [4:0] CIC_CODE_PBUF0 = 5'h12;
  localparam logic [1:0] CIC_MODE_LEGACY = 2'h0;
  localparam logic [1:0] CIC_MODE_ENH = 2'h1;
  localparam logic [1:0] CIC_MODE_FIFO = 2'h2;
  localparam int CIC_NUM_TX = 3;
  localparam int CIC_NUM_PBUF = 6;
  localparam logic [3:0] CIC_SYNC_TQ = 4'h1;
  typedef enum logic [1:0] {
    CIC_ST_IDLE = 2'b00,
    CIC_ST_PICK = 2'b01,
    CIC_ST_SEND = 2'b10
  } cic_tx_state_t;
endpackage
`default_nettype wire

// ---- rtl/cic_bit_timer.sv ----
// Bit timer: divides the clock into time quanta and walks the bit segments.
// Assumes timing fields are held stable while enable is high.
`timescale 1ns/1ps
`default_nettype none
module cic_bit_timer
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic enable_in,
  input wire logic [5:0] prescaler_in,
  input wire logic [2:0] prop_seg_in,
  input wire logic [2:0] phase1_in,
  input wire logic [2:0] phase2_in,
  output logic sample_out,
  output logic bit_end_out
);
  logic [6:0] div_q;
  logic [4:0] tq_q;
  logic tq_tick;
  logic [4:0] bit_len;
  logic [4:0] sample_at;
  // Quantum lasts 2*(prescaler+1) clocks
  assign tq_tick = (div_q == {prescaler_in, 1'b1});
  // Nominal bit time is the sum of all four segments
  assign bit_len = 5'(cic_pkg::CIC_SYNC_TQ) + 5'(prop_seg_in) + 5'(phase1_in) + 5'(phase2_in);
  // Sampling at the end of phase 1, counted from the bit start
  assign sample_at = 5'(cic_pkg::CIC_SYNC_TQ) + 5'(prop_seg_in) + 5'(phase1_in);
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      div_q <= 7'h00;
    else if (!enable_in || tq_tick)
      div_q <= 7'h00;
    else
      div_q <= div_q + 7'h01;
  end
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      tq_q <= 5'h00;
    else if (!enable_in)
      tq_q <= 5'h00;
    else if (tq_tick)
      tq_q <= (tq_q + 5'h01 == bit_len) ? 5'h00 : tq_q + 5'h01;
  end
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      sample_out <= 1'b0;
      bit_end_out <= 1'b0;
    end
    else
    begin
      sample_out <= enable_in && tq_tick && (tq_q + 5'h01 == sample_at);
      bit_end_out <= enable_in && tq_tick && (tq_q + 5'h01 == bit_len);
    end
  end
endmodule
`default_nettype wire

// ---- rtl/cic_core.sv ----
// CAN interrupt code, transmit buffer selection and bit timing registers.
// Assumes APB with 32-bit data; events are one-cycle pulses from the controller.
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cic_core
#(
  parameter int NUM_TX = cic_pkg::CIC_NUM_TX,
  parameter int NUM_PBUF = cic_pkg::CIC_NUM_PBUF
)
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic err_evt_in,
  input wire logic wake_evt_in,
  input wire logic [1:0] rx_evt_in,
  input wire logic [NUM_TX-1:0] tx_evt_in,
  input wire logic [NUM_PBUF-1:0] pbuf_evt_in,
  input wire logic [2:0] op_mode_in,
  input wire logic bus_idle_in,
  input wire logic frame_done_in,
  output logic sof_out,
  output logic [1:0] tx_sel_out,
  output logic tx_active_out,
  output logic sample_out,
  output logic bit_end_out
);
  // Decoders and register layout are written for exactly these buffer counts
  if (NUM_TX != 3 || NUM_PBUF != 6)
  begin : g_bad_params
    $error("cic_core supports three tx and six programmable buffers only");
  end
  logic [1:0] mode_q;
  logic timer_en_q;
  logic [2*NUM_TX-1:0] tx_prio_q;
  logic [NUM_TX-1:0] tx_req_q;
  logic [5:0] brp_q;
  logic [2:0] prop_q;
  logic [2:0] ph1_q;
  logic [2:0] ph2_q;
  logic [1:0] sjw_q;
  logic err_p_q;
  logic wake_p_q;
  logic [1:0] rx_p_q;
  logic [NUM_TX-1:0] tx_p_q;
  logic [NUM_PBUF-1:0] pb_p_q;
  cic_pkg::cic_tx_state_t st_q;
  logic [1:0] sel_q;
  logic sof_q;
  logic [1:0] best_idx;
  logic best_any;
  logic [4:0] icode;
  logic wr_en;
  logic rd_en;
  logic [31:0] rd_d;
  logic addr_ok;
  logic [31:0] irq_clr;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign irq_clr = (wr_en && paddr == cic_pkg::CIC_IRQ_OFFS) ? pwdata : 32'h0;
  function automatic logic hit(input logic [11:0] a);
    hit = (a == cic_pkg::CIC_STATUS_OFFS) || (a == cic_pkg::CIC_CTRL_OFFS) ||
          (a == cic_pkg::CIC_IRQ_OFFS) || (a == cic_pkg::CIC_TXPRIO_OFFS) ||
          (a == cic_pkg::CIC_TIMING_OFFS) || (a == cic_pkg::CIC_BITSTAT_OFFS);
  endfunction
  assign addr_ok = hit(paddr);
  assign pslverr = psel && penable && !addr_ok;
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      mode_q <= cic_pkg::CIC_MODE_LEGACY;
      timer_en_q <= 1'b0;
    end
    else if (wr_en && paddr == cic_pkg::CIC_CTRL_OFFS)
    begin
      mode_q <= (pwdata[1:0] == 2'h3) ? cic_pkg::CIC_MODE_LEGACY : pwdata[1:0];
      timer_en_q <= pwdata[4];
    end
  end
  // Requests clear themselves when the chosen buffer completes
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      tx_prio_q <= '0;
      tx_req_q <= '0;
    end
    else
    begin
      if (wr_en && paddr == cic_pkg::CIC_TXPRIO_OFFS)
      begin
        tx_prio_q <= pwdata[2*NUM_TX-1:0];
        tx_req_q <= pwdata[8 +: NUM_TX];
      end
      else if (st_q == cic_pkg::CIC_ST_SEND && frame_done_in)
        tx_req_q[sel_q] <= 1'b0;
    end
  end
  // Fields accepted as written; ordering between segments is left to software
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      brp_q <= 6'h00;
      prop_q <= 3'h0;
      ph1_q <= 3'h0;
      ph2_q <= 3'h0;
      sjw_q <= 2'h0;
    end
    else if (wr_en && paddr == cic_pkg::CIC_TIMING_OFFS)
    begin
      brp_q <= pwdata[5:0];
      prop_q <= pwdata[10:8];
      ph1_q <= pwdata[14:12];
      ph2_q <= pwdata[18:16];
      sjw_q <= pwdata[21:20];
    end
  end
  // Pending flags: a new event wins over a clear in the same cycle
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      err_p_q <= 1'b0;
      wake_p_q <= 1'b0;
      rx_p_q <= '0;
      tx_p_q <= '0;
      pb_p_q <= '0;
    end
    else
    begin
      err_p_q <= err_evt_in | (err_p_q & ~irq_clr[0]);
      wake_p_q <= wake_evt_in | (wake_p_q & ~irq_clr[1]);
      rx_p_q <= rx_evt_in | (rx_p_q & ~irq_clr[3:2]);
      tx_p_q <= tx_evt_in | (tx_p_q & ~irq_clr[4 +: NUM_TX]);
      pb_p_q <= pbuf_evt_in | (pb_p_q & ~irq_clr[8 +: NUM_PBUF]);
    end
  end
  // Source code, in priority order; rx1 leads rx0 only in legacy mode
  always_comb
  begin
    icode = cic_pkg::CIC_CODE_NONE;
    if (err_p_q)
      icode = cic_pkg::CIC_CODE_ERR;
    else if (wake_p_q && mode_q != cic_pkg::CIC_MODE_LEGACY)
      icode = cic_pkg::CIC_CODE_WAKE;
    else if (wake_p_q)
      icode = cic_pkg::CIC_CODE_ERR;
    else if (tx_p_q[2])
      icode = cic_pkg::CIC_CODE_TX2;
    else if (tx_p_q[1])
      icode = cic_pkg::CIC_CODE_TX1;
    else if (tx_p_q[0])
      icode = cic_pkg::CIC_CODE_TX0;
    else if (rx_p_q[1] && mode_q == cic_pkg::CIC_MODE_LEGACY)
      icode = cic_pkg::CIC_CODE_RX1_LEG;
    else if (rx_p_q[0] && mode_q == cic_pkg::CIC_MODE_LEGACY)
      icode = cic_pkg::CIC_CODE_RX0_LEG;
    else if (rx_p_q[0])
      icode = cic_pkg::CIC_CODE_RX0_ENH;
    else if (rx_p_q[1])
      icode = (mode_q == cic_pkg::CIC_MODE_FIFO) ? cic_pkg::CIC_CODE_RX0_ENH : cic_pkg::CIC_CODE_RX1_ENH;
    else
    begin
      for (int i = NUM_PBUF - 1; i >= 0; i--)
      begin
        if (pb_p_q[i] && mode_q != cic_pkg::CIC_MODE_LEGACY)
          icode = cic_pkg::CIC_CODE_PBUF0 + 5'(i);
      end
    end
  end
  // Only the priority field and index decide; identifiers are never looked at
  always_comb
  begin
    best_idx = 2'h0;
    best_any = 1'b0;
    for (int i = 0; i < NUM_TX; i++)
    begin
      // Later index wins ties through >=
      if (tx_req_q[i] && (!best_any || tx_prio_q[2*i +: 2] >= tx_prio_q[2*best_idx +: 2]))
      begin
        best_idx = 2'(i);
        best_any = 1'b1;
      end
    end
  end
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      st_q <= cic_pkg::CIC_ST_IDLE;
      sel_q <= 2'h0;
      sof_q <= 1'b0;
    end
    else
    begin
      sof_q <= 1'b0;
      case (st_q)
        cic_pkg::CIC_ST_IDLE:
          if (best_any && bus_idle_in)
            st_q <= cic_pkg::CIC_ST_PICK;
        cic_pkg::CIC_ST_PICK:
        begin
          // Comparison repeated right before start of frame, so late queue changes count
          if (best_any)
          begin
            sel_q <= best_idx;
            sof_q <= 1'b1;
            st_q <= cic_pkg::CIC_ST_SEND;
          end
          else
            st_q <= cic_pkg::CIC_ST_IDLE;
        end
        cic_pkg::CIC_ST_SEND:
          if (frame_done_in)
            st_q <= cic_pkg::CIC_ST_IDLE;
        default:
          st_q <= cic_pkg::CIC_ST_IDLE;
      endcase
    end
  end
  assign sof_out = sof_q;
  assign tx_sel_out = sel_q;
  assign tx_active_out = (st_q == cic_pkg::CIC_ST_SEND);
  always_comb
  begin
    rd_d = 32'h0;
    case (paddr)
      cic_pkg::CIC_STATUS_OFFS:
        // Legacy code keeps bits 3:1 in place, with bits 4 and 0 zero
        rd_d = (mode_q == cic_pkg::CIC_MODE_LEGACY) ? {24'h0, op_mode_in, 1'b0, icode[3:1], 1'b0}
                                                   : {24'h0, op_mode_in, icode};
      cic_pkg::CIC_CTRL_OFFS:
        rd_d = {27'h0, timer_en_q, 2'h0, mode_q};
      cic_pkg::CIC_IRQ_OFFS:
        rd_d = {18'h0, pb_p_q, 1'b0, tx_p_q, rx_p_q, wake_p_q, err_p_q};
      cic_pkg::CIC_TXPRIO_OFFS:
        rd_d = {21'h0, tx_req_q, 2'h0, tx_prio_q};
      cic_pkg::CIC_TIMING_OFFS:
        rd_d = {10'h0, sjw_q, 1'b0, ph2_q, 1'b0, ph1_q, 1'b0, prop_q, 2'h0, brp_q};
      cic_pkg::CIC_BITSTAT_OFFS:
        rd_d = {25'h0, tx_active_out, 2'h0, sel_q, 2'h0};
      default:
        rd_d = 32'h0;
    endcase
  end
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
      prdata <= rd_d;
  end
  cic_bit_timer u_timer
  (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .enable_in(timer_en_q),
    .prescaler_in(brp_q),
    .prop_seg_in(prop_q),
    .phase1_in(ph1_q),
    .phase2_in(ph2_q),
    .sample_out(sample_out),
    .bit_end_out(bit_end_out)
  );
endmodule
`default_nettype wire

// ---- verification/cic_core_assertions.sv ----
// Port checker for cic_core: frame start, buffer choice, timer pulses, APB answers.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module cic_core_assertions
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic frame_done_in,
  input wire logic sof_out,
  input wire logic [1:0] tx_sel_out,
  input wire logic tx_active_out,
  input wire logic sample_out,
  input wire logic bit_end_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);
  sequence s_start;
    sof_out ##0 tx_active_out;
  endsequence
  a_frame_start: assert property (sof_out |-> s_start ##0 !$past(tx_active_out))
    else $error("frame start while a frame was active");
  a_sof_single: assert property (sof_out |=> !sof_out)
    else $error("frame start longer than one cycle");
  a_sel_hold: assert property (!sof_out |-> $stable(tx_sel_out))
    else $error("selected buffer changed without frame start");
  a_active_rise: assert property ($rose(tx_active_out) |-> sof_out)
    else $error("frame active without frame start");
  a_active_end: assert property (tx_active_out && frame_done_in |=> !tx_active_out)
    else $error("frame still active after frame end");
  a_active_hold: assert property (tx_active_out && !frame_done_in |=> tx_active_out)
    else $error("frame dropped before frame end");
  a_sample_pulse: assert property (sample_out |=> !sample_out)
    else $error("sample pulse longer than one cycle");
  a_bit_spacing: assert property (bit_end_out |=> !bit_end_out [*3])
    else $error("bit end pulses too close");
  a_bad_addr: assert property (psel && penable && !pwrite && paddr > 12'h014 |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  a_good_addr: assert property (psel && penable && paddr <= 12'h014 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
endmodule
bind cic_core cic_core_assertions u_chk (.core_clk_in, .resetn_in, .psel, .penable, .pwrite, .paddr,
  .prdata, .pslverr, .frame_done_in, .sof_out, .tx_sel_out, .tx_active_out, .sample_out, .bit_end_out);
`default_nettype wire

// ---- verification/cic_can_node_model.sv ----
// Model of the other CAN nodes: holds the bus busy for each frame, then ends it.
// Assumes sof_in is a one-cycle pulse; slow_in lengthens the frames.
`timescale 1ns/1ps
`default_nettype none
module cic_can_node_model
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic slow_in,
  input wire logic sof_in,
  output logic bus_idle_out,
  output logic frame_done_out
);
  logic [5:0] left_q;
  // Frame length has no identifier in it, so it cannot sway the buffer choice
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      left_q <= 6'h00;
      bus_idle_out <= 1'b1;
      frame_done_out <= 1'b0;
    end
    else if (sof_in)
    begin
      left_q <= slow_in ? 6'h28 : 6'h03;
      bus_idle_out <= 1'b0;
    end
    else if (left_q != 6'h00)
    begin
      left_q <= left_q - 6'h01;
      frame_done_out <= (left_q == 6'h01);
    end
    else
    begin
      frame_done_out <= 1'b0;
      bus_idle_out <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Testbench for cic_core: interrupt codes, transmit order, bit timing, APB refusals.
// Assumes the CAN node model answers every frame start.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk_in = 1'b0, resetn_in = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic err_evt_in = 1'b0, wake_evt_in = 1'b0, slow = 1'b0, perr, pready, pslverr;
  logic bus_idle_in, frame_done_in, sof_out, tx_active_out, sample_out, bit_end_out;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0] rx_evt_in = 2'h0, tx_sel_out;
  logic [2:0] tx_evt_in = 3'h0, op_mode_in = 3'h4;
  logic [5:0] pbuf_evt_in = 6'h00;
  int n_mismatch = 0, compares = 0, cyc = 0, j, k;
  initial forever #50 core_clk_in = ~core_clk_in;
  cic_core dut (.core_clk_in, .resetn_in, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .err_evt_in, .wake_evt_in, .rx_evt_in, .tx_evt_in, .pbuf_evt_in, .op_mode_in, .bus_idle_in,
    .frame_done_in, .sof_out, .tx_sel_out, .tx_active_out, .sample_out, .bit_end_out);
  cic_can_node_model u_node (.core_clk_in, .resetn_in, .slow_in(slow), .sof_in(sof_out),
    .bus_idle_out(bus_idle_in), .frame_done_out(frame_done_in));
  task close_out;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge core_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      close_out;
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Request held from setup until pready is seen high at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_in);
    penable <= 1'b1;
    @(posedge core_clk_in);
    while (pready !== 1'b1) @(posedge core_clk_in);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Mask bits: 0 err, 1 wake, 3:2 rx1:rx0, 6:4 tx2..0, 13:8 buffers 5..0
  task irq(input logic [1:0] md, input logic [13:0] m, input logic [4:0] code);
    apb(1'b1, 12'h004, {27'h0, 1'b1, 2'h0, md});
    @(posedge core_clk_in);
    {pbuf_evt_in, tx_evt_in, rx_evt_in, wake_evt_in, err_evt_in} <= {m[13:8], m[6:0]};
    @(posedge core_clk_in);
    {pbuf_evt_in, tx_evt_in, rx_evt_in, wake_evt_in, err_evt_in} <= 13'h0;
    apb(1'b0, 12'h000, 32'h0);
    chk("status", {24'h0, op_mode_in, code}, rd);
    apb(1'b1, 12'h008, 32'h00003fff);
  endtask
  // ord holds the expected buffer order, first in bits 1:0
  task txrun(input logic [5:0] pr, input logic [5:0] ord);
    int i;
    apb(1'b1, 12'h00c, {21'h0, 3'h7, 2'h0, pr});
    for (i = 0; i < 3; i++)
    begin
      for (j = 0; j < 300 && sof_out !== 1'b1; j++) @(negedge core_clk_in);
      chk("tx_sel", {30'h0, ord[2*i +: 2]}, {30'h0, tx_sel_out});
      @(negedge core_clk_in);
    end
    for (j = 0; j < 300 && tx_active_out !== 1'b0; j++) @(negedge core_clk_in);
  endtask
  initial
  begin
    repeat (10) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    apb(1'b1, 12'h010, 32'h00123201);
    apb(1'b0, 12'h010, 32'h0);
    chk("timing", 32'h00123201, rd);
    irq(2'h0, 14'h0000, 5'h00);
    irq(2'h0, 14'h0001, 5'h02);
    irq(2'h0, 14'h0002, 5'h02);
    irq(2'h0, 14'h0040, 5'h04);
    irq(2'h0, 14'h0020, 5'h06);
    irq(2'h0, 14'h0010, 5'h08);
    irq(2'h0, 14'h0008, 5'h0a);
    irq(2'h0, 14'h0004, 5'h0c);
    irq(2'h0, 14'h0018, 5'h08);
    irq(2'h1, 14'h0002, 5'h0e);
    irq(2'h1, 14'h0004, 5'h10);
    irq(2'h1, 14'h0008, 5'h11);
    for (k = 0; k < 6; k++)
      irq(2'h1, 14'h0100 << k, 5'(5'h12 + k));
    irq(2'h2, 14'h0004, 5'h10);
    irq(2'h2, 14'h0008, 5'h10);
    irq(2'h2, 14'h0002, 5'h0e);
    irq(2'h3, 14'h0004, 5'h0c);
    apb(1'b0, 12'h004, 32'h0);
    chk("ctrl", 32'h00000010, rd);
    apb(1'b1, 12'h000, 32'h000000ff);
    apb(1'b0, 12'h000, 32'h0);
    chk("status_ro", {24'h0, op_mode_in, 5'h00}, rd);
    apb(1'b0, 12'h020, 32'h0);
    chk("slverr", 32'h1, {31'h0, perr});
    chk("rdata", 32'h0, rd);
    // Quantum 4 clocks, bit of 8 quanta, sample after 6 quanta
    // Step off the rising edge first, so the pulse is never read as it launches
    @(negedge core_clk_in);
    for (j = 0; j < 100 && bit_end_out !== 1'b1; j++) @(negedge core_clk_in);
    @(negedge core_clk_in);
    for (j = 1; j < 100 && sample_out !== 1'b1; j++) @(negedge core_clk_in);
    chk("sample_at", 32'd24, j);
    @(negedge core_clk_in);
    for (j = j + 1; j < 100 && bit_end_out !== 1'b1; j++) @(negedge core_clk_in);
    chk("bit_len", 32'd32, j);
    txrun(6'h17, 6'h18);
    apb(1'b0, 12'h00c, 32'h0);
    chk("txprio", 32'h00000017, rd);
    apb(1'b0, 12'h014, 32'h0);
    chk("bitstat", 32'h00000004, rd);
    slow <= 1'b1;
    txrun(6'h2a, 6'h06);
    txrun(6'h18, 6'h09);
    close_out;
  end
endmodule
`default_nettype wire
